// [rtl/hitc_pkg.sv]
// Constants for the per-hart interrupt trap control block.
// Assumes a 32-bit APB register bus and 64-bit control registers.
package hitc_pkg;
   // ===================================================================
   // Register byte offsets (each 64-bit register: low word, high word)
   localparam logic [7:0] OFS_STATUS  = 8'h00;
   localparam logic [7:0] OFS_ENABLE  = 8'h08;
   localparam logic [7:0] OFS_PENDING = 8'h10;
   localparam logic [7:0] OFS_CAUSE   = 8'h18;
   localparam logic [7:0] OFS_TVEC    = 8'h20;
   localparam logic [7:0] OFS_EPC     = 8'h28;
   localparam logic [7:0] OFS_DELEG   = 8'h30;
   localparam logic [7:0] OFS_STVEC   = 8'h38;
   localparam logic [7:0] OFS_SEPC    = 8'h40;
   localparam logic [7:0] OFS_SCAUSE  = 8'h48;
   localparam logic [7:0] OFS_PRIV    = 8'h50;
   // ===================================================================
   // Status field positions
   localparam int ST_SIE  = 1;
   localparam int ST_MIE  = 3;
   localparam int ST_SUPERVISOR_PREVIOUS_ENABLE = 5;
   localparam int ST_MACHINE_PREVIOUS_ENABLE = 7;
   localparam int ST_SPP  = 8;
   localparam int ST_MPP  = 11;
   // ===================================================================
   // Interrupt numbers (pending and enable bit positions)
   localparam int IRQ_SSW    = 1;
   localparam int IRQ_MSW    = 3;
   localparam int IRQ_STIMER = 5;
   localparam int IRQ_MTIMER = 7;
   localparam int IRQ_SEXT   = 9;
   localparam int IRQ_MEXT   = 11;
   localparam int IRQ_LOCAL0 = 16;
   localparam int LOCAL_N    = 48;
   // Writable enable bits and delegable interrupts
   localparam logic [63:0] ENABLE_MASK = 64'hFFFF_FFFF_FFFF_0AAA;
   localparam logic [63:0] DELEG_MASK  = 64'h0000_0000_0000_0222;
   localparam logic [63:0] PEND_SWMASK = 64'h0000_0000_0000_0222;
   // ===================================================================
   // Privilege encodings and vector modes
   localparam logic [1:0] PRIV_U = 2'h0;
   localparam logic [1:0] PRIV_S = 2'h1;
   localparam logic [1:0] PRIV_M = 2'h3;
   localparam logic [1:0] MODE_DIRECT = 2'h0;
   localparam logic [1:0] MODE_VECTOR = 2'h1;
   localparam int VEC_SHIFT = 2;
endpackage : hitc_pkg

// [rtl/hitc_top.sv]
// Per-hart machine/supervisor interrupt entry and return control.
// Assumes interrupt inputs are level signals synchronous to CLK and that
// the core presents an instruction boundary and return strobe on CLK.
`timescale 1ns/1ns
module hitc_top #(
   parameter int XLEN = 64
) (
   // Clock, reset, enable
   input  wire logic             CLK,
   input  wire logic             RST,
   input  wire logic             CE,
   // APB slave
   input  wire logic             PSEL,
   input  wire logic             PENABLE,
   input  wire logic             PWRITE,
   input  wire logic [7:0]       PADDR,
   input  wire logic [31:0]      PWDATA,
   output logic      [31:0]      PRDATA,
   output logic                  PREADY,
   output logic                  PSLVERR,
   // Interrupt lines
   input  wire logic             MSW_IRQ,
   input  wire logic             MTIMER_IRQ,
   input  wire logic             MEXT_IRQ,
   input  wire logic [47:0]      LOCAL_IRQ,
   // Core side
   input  wire logic             BOUNDARY,
   input  wire logic             MACHINE_RETURN_INSTRUCTION,
   input  wire logic [XLEN-1:0]  CUR_PC,
   output logic                  REDIRECT,
   output logic                  TRAP_TAKEN,
   output logic      [XLEN-1:0]  TARGET_PC,
   output logic      [1:0]       PRIV
);
   // ===================================================================
   // State
   logic            sie, mie_g, supervisor_previous_enable, machine_previous_enable, supervisor_previous_privilege;
   logic [1:0]      machine_previous_privilege;
   logic [63:0]     enable, deleg, sw_pend;
   logic [XLEN-1:0] cause, tvec, epc, scause, stvec, sepc;
   logic [63:0]     pend, m_cand, s_cand;
   logic            m_ok, s_ok, take_m, take_s, do_ret, wr;
   logic [5:0]      m_code, s_code;
   logic [63:0]     status, rd64, wmerge;
   logic            hit;

   // Highest set bit wins: local lines beat external, timer, software
   function automatic logic [5:0] top_bit(input logic [63:0] v);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 0; i < 64; i++) begin
         if (v[i]) begin
            r = 6'(i);
         end
      end
      return r;
   endfunction : top_bit

   // Mode bits never form part of the base; vectored mode adds four
   // bytes per interrupt code, so each handler slot is one word
   function automatic logic [XLEN-1:0] vec_pc(input logic [XLEN-1:0] tv,
                                               input logic [5:0] code);
      logic [XLEN-1:0] base;
      base = {tv[XLEN-1:2], 2'b00};
      if (tv[1:0] == hitc_pkg::MODE_VECTOR) begin
         return base + (XLEN'(code) << hitc_pkg::VEC_SHIFT);
      end
      return base;
   endfunction : vec_pc

   // ===================================================================
   // Pending vector and selection
   // Software-writable pending bits, overlaid by the live request lines
   always_comb begin
      pend = sw_pend;
      pend[hitc_pkg::IRQ_MSW]    = MSW_IRQ;
      pend[hitc_pkg::IRQ_MTIMER] = MTIMER_IRQ;
      pend[hitc_pkg::IRQ_MEXT]   = MEXT_IRQ;
      pend[63:hitc_pkg::IRQ_LOCAL0] = LOCAL_IRQ;
   end

   assign m_ok   = mie_g;
   // Delegated interrupts are taken only below machine mode, and in
   // supervisor mode only with the supervisor enable set
   assign s_ok   = (PRIV == hitc_pkg::PRIV_U)
                 | ((PRIV == hitc_pkg::PRIV_S) & sie);
   assign m_cand = pend & enable & ~deleg & {64{m_ok}};
   assign s_cand = pend & enable & deleg & {64{s_ok}};
   assign m_code = top_bit(m_cand);
   assign s_code = top_bit(s_cand);
   assign do_ret = CE & MACHINE_RETURN_INSTRUCTION;
   assign take_m = CE & BOUNDARY & ~MACHINE_RETURN_INSTRUCTION & (|m_cand);
   assign take_s = CE & BOUNDARY & ~MACHINE_RETURN_INSTRUCTION & ~(|m_cand) & (|s_cand);

   // ===================================================================
   // APB decode; zero wait states, error on unmapped addresses
   assign PREADY = 1'b1;
   assign wr     = CE & PSEL & PENABLE & PWRITE & hit;

   always_comb begin
      status = '0;
      status[hitc_pkg::ST_SIE]  = sie;
      status[hitc_pkg::ST_MIE]  = mie_g;
      status[hitc_pkg::ST_SUPERVISOR_PREVIOUS_ENABLE] = supervisor_previous_enable;
      status[hitc_pkg::ST_MACHINE_PREVIOUS_ENABLE] = machine_previous_enable;
      status[hitc_pkg::ST_SPP]  = supervisor_previous_privilege;
      status[hitc_pkg::ST_MPP +: 2] = machine_previous_privilege;
      hit  = 1'b1;
      case ({PADDR[7:3], 3'b000})
         hitc_pkg::OFS_STATUS:  rd64 = status;
         hitc_pkg::OFS_ENABLE:  rd64 = enable;
         hitc_pkg::OFS_PENDING: rd64 = pend;
         hitc_pkg::OFS_CAUSE:   rd64 = 64'(cause);
         hitc_pkg::OFS_TVEC:    rd64 = 64'(tvec);
         hitc_pkg::OFS_EPC:     rd64 = 64'(epc);
         hitc_pkg::OFS_DELEG:   rd64 = deleg;
         hitc_pkg::OFS_STVEC:   rd64 = 64'(stvec);
         hitc_pkg::OFS_SEPC:    rd64 = 64'(sepc);
         hitc_pkg::OFS_SCAUSE:  rd64 = 64'(scause);
         hitc_pkg::OFS_PRIV:    rd64 = {62'h0, PRIV};
         default: begin
            rd64 = '0;
            hit  = 1'b0;
         end
      endcase
      if (PADDR[1:0] != 2'b00) begin
         hit = 1'b0;
      end
      wmerge = PADDR[2] ? {PWDATA, rd64[31:0]} : {rd64[63:32], PWDATA};
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         PRDATA  <= 32'h0000_0000;
         PSLVERR <= 1'b0;
      end else if (CE) begin
         PSLVERR <= PSEL & ~PENABLE & ~hit;
         // Read data is captured in the setup cycle, so a trap taken in
         // the access cycle is not yet visible in that read
         if (PSEL & ~PENABLE & ~PWRITE & hit) begin
            PRDATA <= PADDR[2] ? rd64[63:32] : rd64[31:0];
         end
      end
   end

   function automatic logic sel(input logic [7:0] ofs);
      return wr && ({PADDR[7:3], 3'b000} == ofs);
   endfunction : sel

   // ===================================================================
   // Status fields; trap and return take priority over software writes
   always_ff @(posedge CLK) begin
      if (RST) begin
         sie   <= 1'b0;
         mie_g <= 1'b0;
         supervisor_previous_enable  <= 1'b0;
         machine_previous_enable  <= 1'b0;
         supervisor_previous_privilege   <= 1'b0;
         machine_previous_privilege   <= hitc_pkg::PRIV_M;
         PRIV  <= hitc_pkg::PRIV_M;
      end else if (take_m) begin
         machine_previous_enable  <= mie_g;
         mie_g <= 1'b0;
         machine_previous_privilege   <= PRIV;
         PRIV  <= hitc_pkg::PRIV_M;
      end else if (take_s) begin
         supervisor_previous_enable  <= sie;
         sie   <= 1'b0;
         // Supervisor entry keeps only the low bit of the old privilege
         supervisor_previous_privilege   <= PRIV[0];
         PRIV  <= hitc_pkg::PRIV_S;
      end else if (do_ret) begin
         PRIV  <= machine_previous_privilege;
         mie_g <= machine_previous_enable;
         machine_previous_enable  <= 1'b1;
         // Return always drops the previous privilege to user mode
         machine_previous_privilege   <= hitc_pkg::PRIV_U;
      end else if (sel(hitc_pkg::OFS_STATUS) && !PADDR[2]) begin
         sie   <= PWDATA[hitc_pkg::ST_SIE];
         mie_g <= PWDATA[hitc_pkg::ST_MIE];
         supervisor_previous_enable  <= PWDATA[hitc_pkg::ST_SUPERVISOR_PREVIOUS_ENABLE];
         machine_previous_enable  <= PWDATA[hitc_pkg::ST_MACHINE_PREVIOUS_ENABLE];
         supervisor_previous_privilege   <= PWDATA[hitc_pkg::ST_SPP];
         // A reserved previous-privilege value is never stored
         if (PWDATA[hitc_pkg::ST_MPP +: 2] != 2'h2) begin
            machine_previous_privilege <= PWDATA[hitc_pkg::ST_MPP +: 2];
         end
      end
   end

   // ===================================================================
   // Enable, delegation and software pending bits
   // Only implemented bits are stored; unstored enable and delegation bits read back as zero
   always_ff @(posedge CLK) begin
      if (RST) begin
         enable  <= '0;
         deleg   <= '0;
         sw_pend <= '0;
      end else begin
         if (sel(hitc_pkg::OFS_ENABLE)) begin
            enable <= wmerge & hitc_pkg::ENABLE_MASK;
         end
         if (sel(hitc_pkg::OFS_DELEG)) begin
            deleg <= wmerge & hitc_pkg::DELEG_MASK;
         end
         if (sel(hitc_pkg::OFS_PENDING)) begin
            sw_pend <= wmerge & hitc_pkg::PEND_SWMASK;
         end
      end
   end

   // ===================================================================
   // Vector, saved pc and cause registers
   always_ff @(posedge CLK) begin
      if (RST) begin
         tvec   <= '0;
         stvec  <= '0;
         epc    <= '0;
         sepc   <= '0;
         cause  <= '0;
         scause <= '0;
      end else begin
         if (sel(hitc_pkg::OFS_TVEC)) begin
            // Reserved vector modes fall back to direct mode
            tvec <= XLEN'(wmerge);
            if (wmerge[1:0] > hitc_pkg::MODE_VECTOR) begin
               tvec[1:0] <= hitc_pkg::MODE_DIRECT;
            end
         end
         if (sel(hitc_pkg::OFS_STVEC)) begin
            stvec <= XLEN'(wmerge);
            if (wmerge[1:0] > hitc_pkg::MODE_VECTOR) begin
               stvec[1:0] <= hitc_pkg::MODE_DIRECT;
            end
         end
         if (take_m) begin
            epc   <= CUR_PC;
            cause <= {1'b1, (XLEN-7)'(0), m_code};
         end else begin
            // A taken trap overrides a software write in the same cycle
            if (sel(hitc_pkg::OFS_EPC)) begin
               epc <= XLEN'(wmerge);
            end
            if (sel(hitc_pkg::OFS_CAUSE)) begin
               cause <= XLEN'(wmerge);
            end
         end
         if (take_s) begin
            sepc   <= CUR_PC;
            scause <= {1'b1, (XLEN-7)'(0), s_code};
         end else begin
            if (sel(hitc_pkg::OFS_SEPC)) begin
               sepc <= XLEN'(wmerge);
            end
            if (sel(hitc_pkg::OFS_SCAUSE)) begin
               scause <= XLEN'(wmerge);
            end
         end
      end
   end

   // ===================================================================
   // Program counter redirect towards the core
   // TARGET_PC keeps the last target between redirects; the pulses
   // stretch while CE is low because all state freezes
   always_ff @(posedge CLK) begin
      if (RST) begin
         REDIRECT   <= 1'b0;
         TRAP_TAKEN <= 1'b0;
         TARGET_PC  <= '0;
      end else if (CE) begin
         REDIRECT   <= take_m | take_s | do_ret;
         TRAP_TAKEN <= take_m | take_s;
         if (take_m) begin
            TARGET_PC <= vec_pc(tvec, m_code);
         end else if (take_s) begin
            TARGET_PC <= vec_pc(stvec, s_code);
         end else if (do_ret) begin
            TARGET_PC <= epc;
         end
      end
   end
endmodule : hitc_top

// [tb/hitc_checker.sv]
// Port-level assertions for the interrupt trap control block.
// Assumes it is bound to hitc_top and sees only that module's ports.
`timescale 1ns/1ns
module hitc_checker #(
   parameter int XLEN = 64
) (
   // Clock, reset, enable
   input wire logic            CLK, RST, CE,
   // APB slave
   input wire logic            PSEL, PENABLE, PWRITE, PREADY, PSLVERR,
   input wire logic [7:0]      PADDR,
   input wire logic [31:0]     PWDATA, PRDATA,
   // Interrupt lines
   input wire logic            MSW_IRQ, MTIMER_IRQ, MEXT_IRQ,
   input wire logic [47:0]     LOCAL_IRQ,
   // Core side
   input wire logic            BOUNDARY, MACHINE_RETURN_INSTRUCTION, REDIRECT, TRAP_TAKEN,
   input wire logic [XLEN-1:0] CUR_PC, TARGET_PC,
   input wire logic [1:0]      PRIV
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // ===================================================================
   // Request sequences
   sequence ret_req;
      MACHINE_RETURN_INSTRUCTION && CE;
   endsequence
   sequence idle_edge;
      !BOUNDARY && CE;
   endsequence
   // ===================================================================
   // Properties
   trap_redirect_a:
      assert property (TRAP_TAKEN |-> REDIRECT)
      else $error("trap pulse without redirect");
   boundary_only_a:
      assert property (idle_edge |=> !TRAP_TAKEN)
      else $error("trap taken off a boundary");
   return_redirect_a:
      assert property (ret_req |=> REDIRECT && !TRAP_TAKEN)
      else $error("return without plain redirect");
   target_hold_a:
      assert property (!REDIRECT |-> $stable(TARGET_PC))
      else $error("target moved without redirect");
   priv_hold_a:
      assert property (!REDIRECT |-> $stable(PRIV))
      else $error("privilege moved without redirect");
   priv_legal_a:
      assert property (PRIV != 2'h2)
      else $error("reserved privilege value");
   ready_high_a:
      assert property (PREADY)
      else $error("wait state inserted");
   align_err_a:
      assert property (PSEL && PENABLE && PADDR[1:0] != 2'h0 |-> PSLVERR)
      else $error("misaligned access not refused");
   unmapped_err_a:
      assert property (PSEL && PENABLE && PADDR > 8'h54 |-> PSLVERR)
      else $error("unmapped access not refused");
   freeze_priv_a:
      assert property (!CE |=> $stable(PRIV) && $stable(TARGET_PC))
      else $error("state moved while clock enable low");
endmodule : hitc_checker
bind hitc_top hitc_checker #(.XLEN(XLEN)) hitc_checker_i (
   .CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PREADY(PREADY), .PSLVERR(PSLVERR), .PADDR(PADDR),
   .PWDATA(PWDATA), .PRDATA(PRDATA), .MSW_IRQ(MSW_IRQ),
   .MTIMER_IRQ(MTIMER_IRQ), .MEXT_IRQ(MEXT_IRQ), .LOCAL_IRQ(LOCAL_IRQ),
   .BOUNDARY(BOUNDARY), .MACHINE_RETURN_INSTRUCTION(MACHINE_RETURN_INSTRUCTION), .REDIRECT(REDIRECT),
   .TRAP_TAKEN(TRAP_TAKEN), .CUR_PC(CUR_PC), .TARGET_PC(TARGET_PC),
   .PRIV(PRIV));

// [tb/hitc_sources.sv]
// Far-side interrupt sources: core-local software and timer lines,
// the platform controller line and the local lines, all on the core clock.
`timescale 1ns/1ns
module hitc_sources (
   // Clock and reset
   input  wire logic        clk, rst,
   // Requests from the bench
   input  wire logic        want_msw, want_mtimer, want_mext,
   input  wire logic [47:0] want_local,
   // Level lines into the hart
   output logic             msw_irq, mtimer_irq, mext_irq,
   output logic [47:0]      local_irq
);
   always_ff @(posedge clk) begin
      if (rst) begin
         msw_irq    <= 1'b0;
         mtimer_irq <= 1'b0;
         mext_irq   <= 1'b0;
         local_irq  <= 48'h0;
      end else begin
         msw_irq    <= want_msw;
         mtimer_irq <= want_mtimer;
         mext_irq   <= want_mext;
         local_irq  <= want_local;
      end
   end
endmodule : hitc_sources

// [tb/hitc_top_bench.sv]
// Bench: register access, enable gating, trap entry, vectoring, return.
// Assumes hitc_sources drives the interrupt lines on the core clock.
`timescale 1ns/1ns
module hitc_top_bench;
   logic        CLK, RST, CE, PSEL, PENABLE, PWRITE, BOUNDARY, MACHINE_RETURN_INSTRUCTION;
   logic        PREADY, PSLVERR, REDIRECT, TRAP_TAKEN, err;
   logic        MSW_IRQ, MTIMER_IRQ, MEXT_IRQ, w_sw, w_tm, w_ext;
   logic [7:0]  PADDR;
   logic [31:0] PWDATA, PRDATA, rd, d;
   logic [47:0] LOCAL_IRQ, w_loc;
   logic [63:0] CUR_PC, TARGET_PC, v, pc, base;
   logic [1:0]  PRIV;
   int          mismatches, check_count, k, c;
   int          codes [4] = '{3, 7, 11, 63};
   hitc_top hitc_top_i (.CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .MSW_IRQ(MSW_IRQ), .MTIMER_IRQ(MTIMER_IRQ), .MEXT_IRQ(MEXT_IRQ),
      .LOCAL_IRQ(LOCAL_IRQ), .BOUNDARY(BOUNDARY), .MACHINE_RETURN_INSTRUCTION(MACHINE_RETURN_INSTRUCTION),
      .CUR_PC(CUR_PC), .REDIRECT(REDIRECT), .TRAP_TAKEN(TRAP_TAKEN),
      .TARGET_PC(TARGET_PC), .PRIV(PRIV));
   hitc_sources hitc_sources_i (.clk(CLK), .rst(RST), .want_msw(w_sw),
      .want_mtimer(w_tm), .want_mext(w_ext), .want_local(w_loc),
      .msw_irq(MSW_IRQ), .mtimer_irq(MTIMER_IRQ), .mext_irq(MEXT_IRQ),
      .local_irq(LOCAL_IRQ));
   // ===================================================================
   // Expectations
   function automatic logic [63:0] vec_pc(input logic [63:0] b, int n);
      logic [63:0] a;
      a = {b[63:2], 2'h0};
      if (b[1:0] == hitc_pkg::MODE_VECTOR) a = a + 64'(4 * n);
      return a;
   endfunction : vec_pc
   function automatic logic [63:0] cause_of(input int n);
      return {1'b1, 57'h0, 6'(n)};
   endfunction : cause_of
   // ===================================================================
   // Tasks
   task automatic print_verdict;
      $display("mismatches=%0d checks=%0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [63:0] g, input logic [63:0] x);
      check_count++;
      if (g !== x) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask : chk
   task automatic hang(input int i);
      if (i >= 30) begin
         mismatches++;
         print_verdict();
      end
   endtask : hang
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] x);
      int i;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= x;
      @(posedge CLK);
      PENABLE <= 1'b1;
      i = 0;
      do begin
         @(posedge CLK);
         i++;
      end while (PREADY !== 1'b1 && i < 30);
      hang(i);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask : apb
   task automatic rd64(input logic [7:0] a);
      apb(1'b0, a, 32'h0);
      v[31:0] = rd;
      apb(1'b0, a + 8'h04, 32'h0);
      v[63:32] = rd;
   endtask : rd64
   task automatic wr64(input logic [7:0] a, input logic [63:0] x);
      apb(1'b1, a, x[31:0]);
      apb(1'b1, a + 8'h04, x[63:32]);
   endtask : wr64
   task automatic quiet;
      k = 0;
      @(posedge CLK);
      BOUNDARY <= 1'b1;
      repeat (10) begin
         @(posedge CLK);
         #1;
         if (REDIRECT !== 1'b0) k++;
      end
      @(posedge CLK);
      BOUNDARY <= 1'b0;
      chk(k, 0);
   endtask : quiet
   task automatic take(input int n);
      int i;
      pc = {$urandom(), $urandom()};
      @(posedge CLK);
      BOUNDARY <= 1'b1;
      CUR_PC <= pc;
      i = 0;
      do begin
         @(posedge CLK);
         #1;
         i++;
      end while (REDIRECT !== 1'b1 && i < 30);
      hang(i);
      chk(TRAP_TAKEN, 1);
      chk(TARGET_PC, vec_pc(base, n));
      chk(PRIV, hitc_pkg::PRIV_M);
      @(posedge CLK);
      BOUNDARY <= 1'b0;
      rd64(hitc_pkg::OFS_CAUSE);
      chk(v, cause_of(n));
      rd64(hitc_pkg::OFS_EPC);
      chk(v, pc);
      rd64(hitc_pkg::OFS_PENDING);
      chk((v >> n) & 64'h1, 64'h1);
      rd64(hitc_pkg::OFS_STATUS);
      chk(v & 64'h1FFF, 64'h1880);
      @(posedge CLK);
      MACHINE_RETURN_INSTRUCTION <= 1'b1;
      @(posedge CLK);
      MACHINE_RETURN_INSTRUCTION <= 1'b0;
      #1;
      chk({REDIRECT, TRAP_TAKEN}, 2'h2);
      chk(TARGET_PC, pc);
      chk(PRIV, hitc_pkg::PRIV_M);
      rd64(hitc_pkg::OFS_STATUS);
      chk(v & 64'h1FFF, 64'h0088);
   endtask : take
   // ===================================================================
   // Stimulus
   initial begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   initial begin
      {RST, CE, PSEL, PENABLE, PWRITE, BOUNDARY, MACHINE_RETURN_INSTRUCTION} = 7'h60;
      {PADDR, PWDATA, CUR_PC, w_sw, w_tm, w_ext, w_loc} = '0;
      void'($urandom(32'h7653DA61));
      repeat (6) @(posedge CLK);
      RST <= 1'b0;
      rd64(hitc_pkg::OFS_STATUS);
      chk(v, 64'h1800);
      wr64(hitc_pkg::OFS_ENABLE, '1);
      rd64(hitc_pkg::OFS_ENABLE);
      chk(v, hitc_pkg::ENABLE_MASK);
      d = ($urandom() & 32'h01A2) | 32'h1800;
      apb(1'b1, hitc_pkg::OFS_STATUS, d);
      rd64(hitc_pkg::OFS_STATUS);
      chk(v, {32'h0, d});
      apb(1'b1, hitc_pkg::OFS_PENDING, 32'h2);
      rd64(hitc_pkg::OFS_PENDING);
      chk(v & 64'h2, 64'h2);
      apb(1'b1, hitc_pkg::OFS_PENDING, 32'h0);
      apb(1'b1, 8'h02, 32'h0);
      chk(err, 1);
      apb(1'b0, 8'h60, 32'h0);
      chk(err, 1);
      apb(1'b1, hitc_pkg::OFS_STATUS, 32'h1800);
      {w_sw, w_tm, w_ext, w_loc} <= '1;
      quiet();
      wr64(hitc_pkg::OFS_ENABLE, 64'h0);
      apb(1'b1, hitc_pkg::OFS_STATUS, 32'h1808);
      quiet();
      for (int i = 0; i < 8; i++) begin
         c = (i < 4) ? codes[i] : 16 + $urandom_range(47, 0);
         base = {$urandom(), $urandom()};
         base[6:1] = 6'h0;
         w_sw <= 1'b1;
         w_tm <= (c == 7);
         w_ext <= (c == 11);
         w_loc <= (c >= 16) ? 48'h1 << (c - 16) : 48'h0;
         wr64(hitc_pkg::OFS_TVEC, base);
         wr64(hitc_pkg::OFS_ENABLE, (64'h1 << c) | 64'h8);
         take(c);
      end
      // Return to user mode, freeze, then a delegated supervisor trap
      {w_sw, w_tm, w_ext, w_loc} <= '0;
      wr64(hitc_pkg::OFS_DELEG, '1);
      rd64(hitc_pkg::OFS_DELEG);
      chk(v, hitc_pkg::DELEG_MASK);
      base = {$urandom(), $urandom()};
      base[6:1] = 6'h0;
      pc = {$urandom(), $urandom()};
      wr64(hitc_pkg::OFS_STVEC, base);
      wr64(hitc_pkg::OFS_ENABLE, 64'h2);
      apb(1'b1, hitc_pkg::OFS_STATUS, 32'h0008);
      @(posedge CLK);
      MACHINE_RETURN_INSTRUCTION <= 1'b1;
      @(posedge CLK);
      MACHINE_RETURN_INSTRUCTION <= 1'b0;
      #1;
      chk(PRIV, hitc_pkg::PRIV_U);
      apb(1'b1, hitc_pkg::OFS_PENDING, 32'h2);
      @(posedge CLK);
      CE <= 1'b0;
      BOUNDARY <= 1'b1;
      CUR_PC <= pc;
      repeat (4) @(posedge CLK);
      #1;
      chk({REDIRECT, PRIV}, 3'h0);
      @(posedge CLK);
      CE <= 1'b1;
      k = 0;
      do begin
         @(posedge CLK);
         #1;
         k++;
      end while (REDIRECT !== 1'b1 && k < 30);
      hang(k);
      chk(TRAP_TAKEN, 1);
      chk(TARGET_PC, vec_pc(base, hitc_pkg::IRQ_SSW));
      chk(PRIV, hitc_pkg::PRIV_S);
      @(posedge CLK);
      BOUNDARY <= 1'b0;
      rd64(hitc_pkg::OFS_SCAUSE);
      chk(v, cause_of(hitc_pkg::IRQ_SSW));
      rd64(hitc_pkg::OFS_SEPC);
      chk(v, pc);
      rd64(hitc_pkg::OFS_STATUS);
      chk(v & 64'h1FFF, 64'h0080);
      // Reset in mid-run brings back machine mode and clears delegation
      @(posedge CLK);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      #1;
      chk({REDIRECT, TRAP_TAKEN, PRIV}, {2'h0, hitc_pkg::PRIV_M});
      rd64(hitc_pkg::OFS_STATUS);
      chk(v, 64'h1800);
      rd64(hitc_pkg::OFS_DELEG);
      chk(v, 64'h0);
      print_verdict();
   end
endmodule : hitc_top_bench
